// ### logic/dhfs_top.sv
// Converter sleep selection, fault supervision and undervoltage interrupt logic
`timescale 1ns/1ps
module dhfs_top #(
    parameter logic [23:0] BLANK_CYC_0 = dhfs_pkg::BLANK_CYC_0,
    parameter logic [23:0] BLANK_CYC_1 = dhfs_pkg::BLANK_CYC_1,
    parameter logic [23:0] BLANK_CYC_2 = dhfs_pkg::BLANK_CYC_2,
    parameter logic [23:0] BLANK_CYC_3 = dhfs_pkg::BLANK_CYC_3,
    parameter int PERSIST_CYC = dhfs_pkg::PERSIST_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire dhfs_pkg::dhfs_bus_s bus,
    output logic [15:0] rdata,
    input wire logic [5:0] conv_enable,
    input wire logic [5:0] conv_below_95pct,
    input wire logic low_power_request_one,
    input wire logic low_power_request_two,
    input wire logic low_power_request_three,
    input wire logic gpio_sleep_input,
    input wire logic [3:0] ldo_uv_flags,
    output logic [5:0] conv_shutdown,
    output logic system_shutdown,
    output logic conv2_output_off,
    output logic conv5_output_off,
    output logic undervoltage_summary_irq
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [9:0] sync1_reg;
    logic [9:0] sync2_reg;
    wire [9:0] raw_pins = {gpio_sleep_input, low_power_request_three,
        low_power_request_two, low_power_request_one, conv_enable};
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 10'h000;
            sync2_reg <= 10'h000;
        end else begin
            sync1_reg <= raw_pins;
            sync2_reg <= sync1_reg;
        end
    end
    wire [5:0] en_s = sync2_reg[5:0];
    wire [2:0] lp_s = sync2_reg[8:6];
    wire gpio_sleep_s = sync2_reg[9];
    logic [5:0] uv_sync1_reg;
    logic [5:0] uv_sync2_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            uv_sync1_reg <= 6'h00;
            uv_sync2_reg <= 6'h00;
        end else begin
            uv_sync1_reg <= conv_below_95pct;
            uv_sync2_reg <= uv_sync1_reg;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] fault_ctl_reg [dhfs_pkg::NUM_CONV];
    logic [15:0] sleep_c2_reg;
    logic [15:0] sleep_c5_reg;
    logic [15:0] active_opt_reg;
    logic [5:0] uv_mask_reg;
    logic [5:0] uv_flags_reg;
    logic global_sleep_reg;

    function automatic logic [2:0] fault_index(input logic [7:0] a);
        case (a)
            dhfs_pkg::ADDR_FAULT_C1: fault_index = 3'h0;
            dhfs_pkg::ADDR_FAULT_C2: fault_index = 3'h1;
            dhfs_pkg::ADDR_FAULT_C3: fault_index = 3'h2;
            dhfs_pkg::ADDR_FAULT_C4: fault_index = 3'h3;
            dhfs_pkg::ADDR_FAULT_C5: fault_index = 3'h4;
            dhfs_pkg::ADDR_FAULT_C6: fault_index = 3'h5;
            default: fault_index = 3'h7;
        endcase
    endfunction

    wire [2:0] hit_fault = fault_index(bus.addr);
    wire wr_opt = bus.wr && bus.addr == dhfs_pkg::ADDR_ACTIVE_OPT;
    wire wr_c2 = bus.wr && bus.addr == dhfs_pkg::ADDR_SLEEP_C2;
    wire wr_c5 = bus.wr && bus.addr == dhfs_pkg::ADDR_SLEEP_C5;
    wire wr_mask = bus.wr && bus.addr == dhfs_pkg::ADDR_UV_MASK;
    wire wr_gsleep = bus.wr && bus.addr == dhfs_pkg::ADDR_GLOBAL_SLEEP;
    wire rd_flags = bus.rd && bus.addr == dhfs_pkg::ADDR_UV_FLAGS;

    genvar gi;
    generate
        for (gi = 0; gi < dhfs_pkg::NUM_CONV; gi++) begin : g_fctl
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    fault_ctl_reg[gi] <= dhfs_pkg::RESET_VALUE;
                end else if (bus.wr && hit_fault == 3'(gi)) begin
                    fault_ctl_reg[gi] <= bus.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sleep_c2_reg <= dhfs_pkg::RESET_VALUE;
            sleep_c5_reg <= dhfs_pkg::RESET_VALUE;
            active_opt_reg <= dhfs_pkg::RESET_VALUE;
            uv_mask_reg <= 6'h00;
            global_sleep_reg <= 1'b0;
        end else begin
            if (wr_c2) sleep_c2_reg <= bus.wdata;
            if (wr_c5) sleep_c5_reg <= bus.wdata;
            if (wr_opt) active_opt_reg <= bus.wdata;
            if (wr_mask) uv_mask_reg <= bus.wdata[5:0];
            if (wr_gsleep) global_sleep_reg <= bus.wdata[dhfs_pkg::GLOBAL_SLEEP_BIT];
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_fault != 3'h7) begin
            rd_mux = fault_ctl_reg[hit_fault];
        end else begin
            case (bus.addr)
                dhfs_pkg::ADDR_UV_FLAGS: rd_mux = {10'h000, uv_flags_reg};
                dhfs_pkg::ADDR_UV_MASK: rd_mux = {10'h000, uv_mask_reg};
                dhfs_pkg::ADDR_ACTIVE_OPT: rd_mux = active_opt_reg;
                dhfs_pkg::ADDR_SLEEP_C2: rd_mux = sleep_c2_reg;
                dhfs_pkg::ADDR_SLEEP_C5: rd_mux = sleep_c5_reg;
                dhfs_pkg::ADDR_GLOBAL_SLEEP: rd_mux = {15'h0000, global_sleep_reg};
                default: rd_mux = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) rdata <= 16'h0000;
        else if (bus.rd) rdata <= rd_mux;
    end

    // ----------------------------------------
    // Sleep selection
    // ----------------------------------------
    function automatic logic sleep_trigger(input logic [15:0] r, input logic g,
        input logic [2:0] lp, input logic gp);
        logic [1:0] s;
        s = r[dhfs_pkg::SLEEP_SRC_LSB +: 2];
        case (s)
            2'h0: sleep_trigger = g;
            2'h1: sleep_trigger = lp[0];
            2'h2: sleep_trigger = lp[1];
            default: sleep_trigger = lp[2];
        endcase
        sleep_trigger = sleep_trigger | gp;
    endfunction
    wire c2_sleep = sleep_trigger(sleep_c2_reg, global_sleep_reg, lp_s, gpio_sleep_s);
    wire c5_sleep = sleep_trigger(sleep_c5_reg, global_sleep_reg, lp_s, gpio_sleep_s);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            conv2_output_off <= 1'b0;
            conv5_output_off <= 1'b0;
        end else begin
            conv2_output_off <= c2_sleep & sleep_c2_reg[dhfs_pkg::SLEEP_BEHAV_BIT];
            conv5_output_off <= c5_sleep & sleep_c5_reg[dhfs_pkg::SLEEP_BEHAV_BIT];
        end
    end

    // ----------------------------------------
    // Blanking and persistence per converter
    // ----------------------------------------
    logic [1:0] blank_sel;
    logic [23:0] blank_len;
    assign blank_sel = active_opt_reg[dhfs_pkg::BLANK_SEL_LSB +: 2];
    always_comb begin
        case (blank_sel)
            2'h0: blank_len = BLANK_CYC_0;
            2'h1: blank_len = BLANK_CYC_1;
            2'h2: blank_len = BLANK_CYC_2;
            default: blank_len = BLANK_CYC_3;
        endcase
    end

    logic [5:0] en_d_reg;
    logic [5:0] fault_ok_reg;
    logic [5:0] fault_ok_d_reg;
    logic [23:0] blank_cnt_reg [dhfs_pkg::NUM_CONV];
    logic [15:0] pers_cnt_reg [dhfs_pkg::NUM_CONV];
    wire [5:0] fault_rise = fault_ok_reg & ~fault_ok_d_reg;

    generate
        for (gi = 0; gi < dhfs_pkg::NUM_CONV; gi++) begin : g_conv
            wire start = en_s[gi] & ~en_d_reg[gi];
            wire blanked = blank_cnt_reg[gi] != 24'h000000;
            wire cond = uv_sync2_reg[gi] & en_s[gi] & ~blanked & ~start;
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    blank_cnt_reg[gi] <= 24'h000000;
                    pers_cnt_reg[gi] <= 16'h0000;
                    fault_ok_reg[gi] <= 1'b0;
                end else begin
                    if (start) blank_cnt_reg[gi] <= blank_len;
                    else if (blanked) blank_cnt_reg[gi] <= blank_cnt_reg[gi] - 24'h000001;
                    if (!cond) pers_cnt_reg[gi] <= 16'h0000;
                    else if (pers_cnt_reg[gi] < 16'(PERSIST_CYC))
                        pers_cnt_reg[gi] <= pers_cnt_reg[gi] + 16'h0001;
                    fault_ok_reg[gi] <= cond && pers_cnt_reg[gi] >= 16'(PERSIST_CYC - 1);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Fault actions and flags
    // ----------------------------------------
    logic [5:0] conv_off_hit;
    logic [5:0] sys_off_hit;
    always_comb begin
        conv_off_hit = 6'h00;
        sys_off_hit = 6'h00;
        for (int i = 0; i < dhfs_pkg::NUM_CONV; i++) begin
            case (dhfs_pkg::dhfs_action_e'(fault_ctl_reg[i][dhfs_pkg::FAULT_ACT_LSB +: 2]))
                dhfs_pkg::ACT_IGNORE: ;
                dhfs_pkg::ACT_CONV_OFF: conv_off_hit[i] = fault_rise[i];
                default: sys_off_hit[i] = fault_rise[i];
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            en_d_reg <= 6'h00;
            fault_ok_d_reg <= 6'h00;
            uv_flags_reg <= 6'h00;
            conv_shutdown <= 6'h00;
            system_shutdown <= 1'b0;
        end else begin
            en_d_reg <= en_s;
            fault_ok_d_reg <= fault_ok_reg;
            // Set wins over read clear
            uv_flags_reg <= (rd_flags ? 6'h00 : uv_flags_reg) | fault_rise;
            conv_shutdown <= (conv_shutdown & en_s) | conv_off_hit;
            system_shutdown <= system_shutdown | (|sys_off_hit);
        end
    end

    assign undervoltage_summary_irq = |(uv_flags_reg & ~uv_mask_reg) | (|ldo_uv_flags);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_flag_read;
        rd_flags && fault_rise == 6'h00;
    endsequence
    a_flag_read_clear: assert property (@(posedge mclk) disable iff (!rstn)
        s_flag_read |=> uv_flags_reg == 6'h00) else $error("flags not cleared by read");
    a_flag_set_rise: assert property (@(posedge mclk) disable iff (!rstn)
        fault_rise[0] |=> uv_flags_reg[0]) else $error("flag 0 not set on fault");
    a_irq_masked: assert property (@(posedge mclk) disable iff (!rstn)
        (uv_flags_reg & ~uv_mask_reg) == 6'h00 && ldo_uv_flags == 4'h0
        |-> !undervoltage_summary_irq) else $error("masked flag raised irq");
    a_irq_ldo: assert property (@(posedge mclk) disable iff (!rstn)
        |ldo_uv_flags |-> undervoltage_summary_irq) else $error("ldo flag missed");
    a_sys_off_act: assert property (@(posedge mclk) disable iff (!rstn)
        fault_rise[1] && fault_ctl_reg[1][15] |=> system_shutdown)
        else $error("system shutdown missed");
    a_conv_off_act: assert property (@(posedge mclk) disable iff (!rstn)
        fault_rise[2] && fault_ctl_reg[2][15:14] == 2'h1 |=> conv_shutdown[2])
        else $error("converter shutdown missed");
    a_blank_hold: assert property (@(posedge mclk) disable iff (!rstn)
        blank_cnt_reg[3] != 24'h000000 |-> !fault_ok_reg[3]) else $error("fault in blanking");
    a_persist_need: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(fault_ok_reg[4]) |-> $past(pers_cnt_reg[4]) >= 16'(PERSIST_CYC - 1))
        else $error("fault accepted too soon");
    a_sleep_gpio: assert property (@(posedge mclk) disable iff (!rstn)
        gpio_sleep_s && sleep_c2_reg[12] ##1 sleep_c2_reg[12] |-> conv2_output_off)
        else $error("gpio sleep ignored");
    a_sleep_keep: assert property (@(posedge mclk) disable iff (!rstn)
        !$past(sleep_c5_reg[12]) |-> !conv5_output_off) else $error("output off in keep mode");
    sequence s_any_rise;
        fault_rise != 6'h00;
    endsequence
    sequence s_conv0_start;
        en_s[0] && !en_d_reg[0];
    endsequence
    sequence s_c2_lp_one;
        sleep_c2_reg[dhfs_pkg::SLEEP_SRC_LSB +: 2] == 2'h1 && lp_s[0]
            && sleep_c2_reg[dhfs_pkg::SLEEP_BEHAV_BIT];
    endsequence
    a_flag_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !rd_flags && fault_rise == 6'h00 |=> uv_flags_reg == $past(uv_flags_reg))
        else $error("flag changed with no event");
    a_flag_any_rise: assert property (@(posedge mclk) disable iff (!rstn)
        s_any_rise |=> (uv_flags_reg & $past(fault_rise)) == $past(fault_rise))
        else $error("fault did not raise its flag");
    a_blank_load: assert property (@(posedge mclk) disable iff (!rstn)
        s_conv0_start |=> blank_cnt_reg[0] == $past(blank_len))
        else $error("blanking not loaded on start");
    a_persist_level: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(fault_ok_reg[4]) |-> $past(uv_sync2_reg[4]) && $past(uv_sync2_reg[4], PERSIST_CYC))
        else $error("fault accepted without steady condition");
    a_sleep_lp_one: assert property (@(posedge mclk) disable iff (!rstn)
        s_c2_lp_one |=> conv2_output_off) else $error("low-power request one ignored");
    a_gpio_conv5: assert property (@(posedge mclk) disable iff (!rstn)
        gpio_sleep_s && sleep_c5_reg[dhfs_pkg::SLEEP_BEHAV_BIT] |=> conv5_output_off)
        else $error("gpio sleep ignored on converter 5");
    a_sys_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        system_shutdown |=> system_shutdown) else $error("system shutdown dropped");
    a_irq_unmasked: assert property (@(posedge mclk) disable iff (!rstn)
        (uv_flags_reg & ~uv_mask_reg) != 6'h00 |-> undervoltage_summary_irq)
        else $error("unmasked flag missed");
    a_rdata_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !bus.rd |=> $stable(rdata)) else $error("read data changed without read");
endmodule

// ### logic/dhfs_pkg.sv
// Package of constants and types for the converter hibernate and fault supervisor
package dhfs_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_UV_FLAGS = 8'h1C;
    localparam logic [7:0] ADDR_UV_MASK = 8'h24;
    localparam logic [7:0] ADDR_ACTIVE_OPT = 8'hB1;
    localparam logic [7:0] ADDR_FAULT_C1 = 8'hB5;
    localparam logic [7:0] ADDR_SLEEP_C2 = 8'hB7;
    localparam logic [7:0] ADDR_FAULT_C2 = 8'hB8;
    localparam logic [7:0] ADDR_FAULT_C3 = 8'hBB;
    localparam logic [7:0] ADDR_FAULT_C4 = 8'hBE;
    localparam logic [7:0] ADDR_SLEEP_C5 = 8'hC0;
    localparam logic [7:0] ADDR_FAULT_C5 = 8'hC1;
    localparam logic [7:0] ADDR_FAULT_C6 = 8'hC4;
    localparam logic [7:0] ADDR_GLOBAL_SLEEP = 8'hD0;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int SLEEP_BEHAV_BIT = 12;
    localparam int SLEEP_SRC_LSB = 8;
    localparam int FAULT_ACT_LSB = 14;
    localparam int BLANK_SEL_LSB = 12;
    localparam int GLOBAL_SLEEP_BIT = 0;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam int NUM_CONV = 6;
    localparam int NUM_LDO = 4;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ = 20000000;
    localparam longint BLANK_US_0 = 500;
    localparam longint BLANK_US_1 = 2000;
    localparam longint BLANK_US_2 = 32000;
    localparam longint BLANK_US_3 = 256000;
    localparam logic [23:0] BLANK_CYC_0 = 24'(BLANK_US_0 * CLK_HZ / 1000000);
    localparam logic [23:0] BLANK_CYC_1 = 24'(BLANK_US_1 * CLK_HZ / 1000000);
    localparam logic [23:0] BLANK_CYC_2 = 24'(BLANK_US_2 * CLK_HZ / 1000000);
    localparam logic [23:0] BLANK_CYC_3 = 24'(BLANK_US_3 * CLK_HZ / 1000000);
    localparam int PERSIST_CYC = 16;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ACT_IGNORE,
        ACT_CONV_OFF,
        ACT_SYS_OFF,
        ACT_SYS_OFF_RSVD
    } dhfs_action_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dhfs_bus_s;
endpackage

// ### dv/dhfs_conv_model.sv
// Behavioural model of the converter stages, their monitors and the low-power request lines
`timescale 1ns/1ps
module dhfs_conv_model (
    input wire logic mclk,
    input wire logic [5:0] conv_enable,
    input wire logic [5:0] uv_req,
    input wire logic slow,
    input wire logic [2:0] lp_req,
    output logic [5:0] conv_below_95pct,
    output logic low_power_request_one,
    output logic low_power_request_two,
    output logic low_power_request_three
);
    logic [5:0] uv_dly;
    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        uv_dly <= uv_req;
    end
    // Output under target only while the stage runs
    assign conv_below_95pct = (slow ? uv_dly : uv_req) & conv_enable;
    // ----------------------------------------
    // Request lines, active high
    // ----------------------------------------
    assign low_power_request_one = lp_req[0];
    assign low_power_request_two = lp_req[1];
    assign low_power_request_three = lp_req[2];
endmodule

// ### dv/dcdc_hibernate_fault_supervisor_tb_top.sv
// Self-checking testbench of the converter sleep and fault supervisor
`timescale 1ns/1ps
module dcdc_hibernate_fault_supervisor_tb_top;
    localparam int P = 4;
    logic mclk = 0, rstn = 0, slow = 0, gpio = 0;
    dhfs_pkg::dhfs_bus_s bus = '0;
    logic [15:0] rdata, d;
    logic [5:0] en = 0, uv = 0, below, shut;
    logic [2:0] lp = 0, lpw;
    logic [3:0] ldo = 0;
    logic sys, off2, off5, irq;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    int flags_exp = 0, mask_exp = 0, sys_exp = 0, act, sel, b, i, s, r;
    logic [7:0] fa [6] = '{dhfs_pkg::ADDR_FAULT_C1, dhfs_pkg::ADDR_FAULT_C2,
        dhfs_pkg::ADDR_FAULT_C3, dhfs_pkg::ADDR_FAULT_C4, dhfs_pkg::ADDR_FAULT_C5,
        dhfs_pkg::ADDR_FAULT_C6};
    logic [7:0] ra [6] = '{dhfs_pkg::ADDR_UV_FLAGS, dhfs_pkg::ADDR_UV_MASK,
        dhfs_pkg::ADDR_ACTIVE_OPT, dhfs_pkg::ADDR_SLEEP_C2, dhfs_pkg::ADDR_SLEEP_C5, 8'h50};
    always #25 mclk = ~mclk;
    dhfs_top #(.BLANK_CYC_0(24'd20), .BLANK_CYC_1(24'd40), .BLANK_CYC_2(24'd60),
        .BLANK_CYC_3(24'd80), .PERSIST_CYC(P)) dut_u (.mclk(mclk), .rstn(rstn), .bus(bus),
        .rdata(rdata), .conv_enable(en), .conv_below_95pct(below),
        .low_power_request_one(lpw[0]), .low_power_request_two(lpw[1]),
        .low_power_request_three(lpw[2]), .gpio_sleep_input(gpio), .ldo_uv_flags(ldo),
        .conv_shutdown(shut), .system_shutdown(sys), .conv2_output_off(off2),
        .conv5_output_off(off5), .undervoltage_summary_irq(irq));
    dhfs_conv_model far_u (.mclk(mclk), .conv_enable(en), .uv_req(uv), .slow(slow),
        .lp_req(lp), .conv_below_95pct(below), .low_power_request_one(lpw[0]),
        .low_power_request_two(lpw[1]), .low_power_request_three(lpw[2]));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus <= '0;
        #1 d = rdata;
    endtask
    task automatic pulse(input int k, input int n);
        @(posedge mclk) uv[k] <= 1'b1;
        repeat (n) @(posedge mclk);
        uv[k] <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(20));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rd(ra[i]);
            check("reset value", d, 16'h0000);
            r = $urandom;
            wr(ra[i], 16'(r));
            rd(ra[i]);
            if (i == 0 || i == 5) check("read only", d, 16'h0000);
            else if (i == 1) check("mask", d, 16'(r) & 16'h003F);
            else check("control", d, 16'(r));
        end
        $display("test registers done");
        for (s = 0; s < 4; s++) for (b = 0; b < 2; b++) begin
            wr(dhfs_pkg::ADDR_SLEEP_C2, 16'((b << 12) | (s << 8)));
            wr(dhfs_pkg::ADDR_SLEEP_C5, 16'((b << 12) | (s << 8)));
            wr(dhfs_pkg::ADDR_GLOBAL_SLEEP, (s == 0) ? 16'h0001 : 16'h0000);
            rd(dhfs_pkg::ADDR_GLOBAL_SLEEP);
            check("global sleep", d, (s == 0) ? 16'h0001 : 16'h0000);
            @(posedge mclk) lp <= (s == 0) ? 3'h0 : 3'(1 << (s - 1));
            repeat (6) @(posedge mclk);
            check("conv2 off", 16'(off2), 16'(b));
            check("conv5 off", 16'(off5), 16'(b));
            wr(dhfs_pkg::ADDR_GLOBAL_SLEEP, (s == 0) ? 16'h0000 : 16'h0001);
            @(posedge mclk) lp <= (s == 0) ? 3'h7 : ~3'(1 << (s - 1));
            repeat (6) @(posedge mclk);
            check("conv2 other", 16'(off2), 16'h0000);
            check("conv5 other", 16'(off5), 16'h0000);
            @(posedge mclk) gpio <= 1'b1;
            repeat (6) @(posedge mclk);
            check("gpio conv2", 16'(off2), 16'(b));
            check("gpio conv5", 16'(off5), 16'(b));
            @(posedge mclk) gpio <= 1'b0;
            lp <= 3'h0;
        end
        $display("test sleep done");
        for (i = 0; i < 6; i++) begin
            act = i % 4;
            sel = (i + 1) % 4;
            b = 20 * (sel + 1);
            mask_exp = $urandom & 32'h3F;
            wr(dhfs_pkg::ADDR_ACTIVE_OPT, 16'(sel << 12));
            wr(fa[i], 16'(act << 14));
            rd(fa[i]);
            check("fault control", d, 16'(act << 14));
            wr(dhfs_pkg::ADDR_UV_MASK, 16'(mask_exp));
            @(posedge mclk) en[i] <= 1'b1;
            slow <= i[0];
            repeat (b - 12) @(posedge mclk);
            pulse(i, 8);
            repeat (10) @(posedge mclk);
            pulse(i, P - 2);
            repeat (8) @(posedge mclk);
            rd(dhfs_pkg::ADDR_UV_FLAGS);
            check("blank and glitch", d, 16'h0000);
            @(posedge mclk) uv[i] <= 1'b1;
            repeat (P + 8) @(posedge mclk);
            flags_exp = 1 << i;
            if (act >= 2) sys_exp = 1;
            #1 check("irq", 16'(irq), 16'(|(flags_exp & ~mask_exp)));
            check("conv shutdown", 16'(shut), (act == 1) ? 16'(flags_exp) : 16'h0000);
            check("sys shutdown", 16'(sys), 16'(sys_exp));
            rd(dhfs_pkg::ADDR_UV_FLAGS);
            check("flags", d, 16'(flags_exp));
            flags_exp = 0;
            rd(dhfs_pkg::ADDR_UV_FLAGS);
            check("flags cleared", d, 16'h0000);
            check("irq cleared", 16'(irq), 16'h0000);
            @(posedge mclk) uv[i] <= 1'b0;
            en[i] <= 1'b0;
            repeat (5) @(posedge mclk);
            check("shutdown released", 16'(shut), 16'h0000);
        end
        $display("test faults done");
        for (i = 0; i < 4; i++) begin
            @(posedge mclk) ldo <= 4'($urandom);
            @(posedge mclk) #1;
            check("ldo irq", 16'(irq), 16'(|ldo));
        end
        $display("test regulator flags done");
        final_report();
    end
endmodule
